/* File: hsc_consts.vh */
// constants for the hot-swap and strap control block
`ifndef HSC_CONSTS_VH
`define HSC_CONSTS_VH

// --------------------------------------------------------------
// register word indexes
// --------------------------------------------------------------
`define HSC_ADDR_STRAPS 4'h0
`define HSC_ADDR_MISC2 4'h1
`define HSC_ADDR_HSCTL 4'h2
`define HSC_ADDR_INTSTAT 4'h3
`define HSC_ADDR_INTMASK 4'h4

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define HSC_STRAP_EEPROM 0
`define HSC_STRAP_SDA 1
`define HSC_STRAP_ARBITER 2
`define HSC_STRAP_HOLD 3
`define HSC_STRAP_LOAD 4
`define HSC_MISC2_HOLD 0
`define HSC_CTL_CONNECTED 0
`define HSC_CTL_EVENTACK 1
`define HSC_CTL_PMEREQ 2
`define HSC_CTL_STAGE_LSB 4
`define HSC_INT_LATCHOPEN 0
`define HSC_INT_LATCHCLOSE 1
`define HSC_INT_PWRGOOD 2
`define HSC_INT_PWRLOST 3
`define HSC_INT_PMEREQ 4

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define HSC_RST_INTSTAT 8'h00
`define HSC_RST_INTMASK 8'h00
`define HSC_RST_BYTE 8'h00

// --------------------------------------------------------------
// timing counts
// --------------------------------------------------------------
`define HSC_SCL_DIV_EXP 10
`define HSC_STRAP_CAPTURE_CYCLE 2'h2

`endif

/* File: hsc_sync.v */
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module hsc_sync #(
    parameter WIDTH = 6
) (
    input wire mclk,
    input wire rst_b,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // ------------------------------------------------------------
    // first stage feeds only the second stage
    // ------------------------------------------------------------
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;

endmodule // hsc_sync

`default_nettype wire

/* File: hsc_hotswap_strap_control.v */
// hot-swap indicator, ejector sense, strap capture and power event control
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.vh"

module hsc_hotswap_strap_control (
    input wire mclk,
    input wire rst_b,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [7:0] regRdData,
    input wire eeprom_load_strap,
    input wire arbiter_enable_strap,
    input wire config_hold_strap,
    input wire ejector_latch_sense,
    input wire backend_power_good_n,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    output reg sclOut,
    output wire swap_indicator_drive,
    output wire swapIndicatorOe,
    output wire insertEventOut,
    output wire insertEventOe,
    output wire power_event_request_n,
    output wire powerEventOe,
    input wire cfgCycle,
    output wire cfgAccept,
    output wire cfgRetry,
    output reg eepromLoadEnable,
    output reg eepromLoadStart,
    output reg arbiterEnable,
    output wire backendPowerStable,
    output wire irq
);

    // ------------------------------------------------------------
    // stage codes
    // ------------------------------------------------------------
    localparam [3:0] ST_HWCONN = 4'h1;
    localparam [3:0] ST_SWCONN = 4'h2;
    localparam [3:0] ST_NORMAL = 4'h4;
    localparam [3:0] ST_EXTRACT = 4'h8;

    // sticky bit next value: hardware set wins over software clear
    function [7:0] stickyNext;
        input [7:0] cur;
        input [7:0] setBits;
        input [7:0] clrBits;
        begin
            stickyNext = (cur & ~clrBits) | setBits;
        end
    endfunction

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    wire [5:0] syncBits;
    wire eepromStrapS;
    wire arbiterStrapS;
    wire holdStrapS;
    wire latchSenseS;
    wire powerGoodNS;
    wire sdaS;

    hsc_sync #(
        .WIDTH(6)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .asyncIn({sdaIn, backend_power_good_n, ejector_latch_sense, config_hold_strap,
                  arbiter_enable_strap, eeprom_load_strap}),
        .syncOut(syncBits)
    );

    assign eepromStrapS = syncBits[0];
    assign arbiterStrapS = syncBits[1];
    assign holdStrapS = syncBits[2];
    assign latchSenseS = syncBits[3];
    assign powerGoodNS = syncBits[4];
    assign sdaS = syncBits[5];

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    reg [1:0] capCnt_q;
    reg captured_q;
    reg eepromStrap_q;
    reg sdaStrap_q;
    reg holdStrap_q;
    reg configHold_q;
    reg [3:0] stage_q;
    reg [3:0] stage_d;
    reg insertPend_q;
    reg pmeReq_q;
    reg latchOpenPrev_q;
    reg powerStablePrev_q;
    reg [7:0] intStat_q;
    reg [7:0] intMask_q;
    reg [`HSC_SCL_DIV_EXP-1:0] divCnt_q;
    wire [`HSC_SCL_DIV_EXP-1:0] divCnt_d;
    wire latchOpen;
    wire capturePulse;
    wire ctlWrite;
    wire connectedWr;
    wire eventAckWr;
    wire pmeReqWr;
    wire intStatWr;
    wire [7:0] intSet;
    wire [7:0] intClr;
    wire enterEventStage;

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    // synced straps settle two edges after release, so capture on the third
    assign capturePulse = !captured_q && (capCnt_q == `HSC_STRAP_CAPTURE_CYCLE);

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            capCnt_q <= 2'h0;
            captured_q <= 1'b0;
            eepromStrap_q <= 1'b0;
            sdaStrap_q <= 1'b0;
            holdStrap_q <= 1'b0;
            arbiterEnable <= 1'b0;
            eepromLoadEnable <= 1'b0;
            eepromLoadStart <= 1'b0;
        end
        else
        begin
            eepromLoadStart <= 1'b0;
            if (!captured_q)
            begin
                capCnt_q <= capCnt_q + 2'h1;
            end
            // values frozen once taken, later strap moves ignored
            if (capturePulse)
            begin
                captured_q <= 1'b1;
                eepromStrap_q <= eepromStrapS;
                sdaStrap_q <= sdaS;
                holdStrap_q <= holdStrapS;
                arbiterEnable <= arbiterStrapS;
                eepromLoadEnable <= eepromStrapS | sdaS;
                eepromLoadStart <= eepromStrapS | sdaS;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration hold bit
    // ------------------------------------------------------------
    // set from the strap, software may only clear it
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            configHold_q <= 1'b1;
        end
        else if (!captured_q)
        begin
            configHold_q <= capturePulse ? holdStrapS : 1'b1;
        end
        else if (regWrEn && regAddr == `HSC_ADDR_MISC2 && !regWrData[`HSC_MISC2_HOLD])
        begin
            configHold_q <= 1'b0;
        end
    end

    // retry while held, accept only once released
    assign cfgRetry = cfgCycle & configHold_q;
    assign cfgAccept = cfgCycle & ~configHold_q;

    // ------------------------------------------------------------
    // power and ejector sensing
    // ------------------------------------------------------------
    // rst_b low or power-good-bad high both mean power not yet stable
    assign backendPowerStable = captured_q & ~powerGoodNS;
    assign latchOpen = ~latchSenseS;

    // ------------------------------------------------------------
    // software control strobes
    // ------------------------------------------------------------
    assign ctlWrite = regWrEn && (regAddr == `HSC_ADDR_HSCTL);
    assign connectedWr = ctlWrite && regWrData[`HSC_CTL_CONNECTED];
    assign eventAckWr = ctlWrite && regWrData[`HSC_CTL_EVENTACK];
    assign pmeReqWr = ctlWrite && regWrData[`HSC_CTL_PMEREQ];

    // ------------------------------------------------------------
    // hot-swap stage machine
    // ------------------------------------------------------------
    always @*
    begin
        stage_d = stage_q;
        case (stage_q)
            ST_HWCONN:
            begin
                if (backendPowerStable && !latchOpen)
                begin
                    stage_d = ST_SWCONN;
                end
            end
            ST_SWCONN:
            begin
                if (!backendPowerStable)
                begin
                    stage_d = ST_HWCONN;
                end
                else if (connectedWr)
                begin
                    stage_d = ST_NORMAL;
                end
            end
            ST_NORMAL:
            begin
                if (!backendPowerStable)
                begin
                    stage_d = ST_HWCONN;
                end
                else if (latchOpen)
                begin
                    stage_d = ST_EXTRACT;
                end
            end
            ST_EXTRACT:
            begin
                if (!backendPowerStable)
                begin
                    stage_d = ST_HWCONN;
                end
                else if (!latchOpen)
                begin
                    stage_d = ST_SWCONN;
                end
            end
            default:
            begin
                stage_d = ST_HWCONN;
            end
        endcase
    end

    assign enterEventStage = (stage_d != stage_q) &&
                             (stage_d == ST_SWCONN || stage_d == ST_EXTRACT);

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_q <= ST_HWCONN;
        end
        else
        begin
            stage_q <= stage_d;
        end
    end

    // ------------------------------------------------------------
    // insertion event pending flag
    // ------------------------------------------------------------
    // a new stage entry beats a simultaneous acknowledge
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            insertPend_q <= 1'b0;
        end
        else if (enterEventStage)
        begin
            insertPend_q <= 1'b1;
        end
        else if (eventAckWr)
        begin
            insertPend_q <= 1'b0;
        end
    end

    // open-drain event, held back while configuration is on hold
    assign insertEventOut = 1'b0;
    assign insertEventOe = insertPend_q & ~configHold_q;

    // ------------------------------------------------------------
    // indicator pin
    // ------------------------------------------------------------
    // lit in both connection stages and during extraction, else floated
    assign swap_indicator_drive = 1'b0;
    assign swapIndicatorOe = (stage_q != ST_NORMAL);

    // ------------------------------------------------------------
    // power event request
    // ------------------------------------------------------------
    // asserted on software request or loss of back-end power
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pmeReq_q <= 1'b0;
        end
        else if (pmeReqWr || intSet[`HSC_INT_PWRLOST])
        begin
            pmeReq_q <= 1'b1;
        end
        else if (eventAckWr)
        begin
            pmeReq_q <= 1'b0;
        end
    end

    assign power_event_request_n = 1'b0;
    assign powerEventOe = pmeReq_q;

    // ------------------------------------------------------------
    // eeprom serial clock divider
    // ------------------------------------------------------------
    assign divCnt_d = divCnt_q + {{(`HSC_SCL_DIV_EXP-1){1'b0}}, 1'b1};

    // top bit of a ten-bit counter toggles every 512 edges
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCnt_q <= {`HSC_SCL_DIV_EXP{1'b0}};
            sclOut <= 1'b0;
        end
        else
        begin
            divCnt_q <= divCnt_d;
            sclOut <= divCnt_d[`HSC_SCL_DIV_EXP-1];
        end
    end

    // data line is only sampled here, never driven
    assign sdaOut = 1'b0;
    assign sdaOe = 1'b0;

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    assign intStatWr = regWrEn && (regAddr == `HSC_ADDR_INTSTAT);
    assign intClr = intStatWr ? regWrData : 8'h00;
    assign intSet = {3'h0,
                     pmeReqWr,
                     powerStablePrev_q & ~backendPowerStable,
                     ~powerStablePrev_q & backendPowerStable,
                     latchOpenPrev_q & ~latchOpen & captured_q,
                     ~latchOpenPrev_q & latchOpen & captured_q};

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latchOpenPrev_q <= 1'b0;
            powerStablePrev_q <= 1'b0;
            intStat_q <= `HSC_RST_INTSTAT;
            intMask_q <= `HSC_RST_INTMASK;
        end
        else
        begin
            latchOpenPrev_q <= latchOpen;
            powerStablePrev_q <= backendPowerStable;
            intStat_q <= stickyNext(intStat_q, intSet, intClr);
            if (regWrEn && regAddr == `HSC_ADDR_INTMASK)
            begin
                intMask_q <= regWrData;
            end
        end
    end

    assign irq = |(intStat_q & intMask_q);

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // data stands only in the cycle after the read strobe
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regRdData <= `HSC_RST_BYTE;
        end
        else if (regRdEn)
        begin
            case (regAddr)
                `HSC_ADDR_STRAPS:
                    regRdData <= {3'h0, eepromLoadEnable, holdStrap_q, arbiterEnable,
                                  sdaStrap_q, eepromStrap_q};
                `HSC_ADDR_MISC2:
                    regRdData <= {7'h00, configHold_q};
                `HSC_ADDR_HSCTL:
                    regRdData <= {stage_q, 1'b0, pmeReq_q, insertPend_q, latchOpen};
                `HSC_ADDR_INTSTAT:
                    regRdData <= intStat_q;
                `HSC_ADDR_INTMASK:
                    regRdData <= intMask_q;
                default:
                    regRdData <= `HSC_RST_BYTE;
            endcase
        end
        else
        begin
            regRdData <= `HSC_RST_BYTE;
        end
    end

endmodule // hsc_hotswap_strap_control

`default_nettype wire

/* File: hsc_sync_unused_guard.v */
// holds no logic; the synchroniser module lives in hsc_sync.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: hsc_hotswap_monitor.sv */
// assertion checker for the hot-swap and strap control block
`timescale 1ns/1ps
`default_nettype none
module hsc_hotswap_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic eepromLoadStart,
    input wire logic eepromLoadEnable,
    input wire logic arbiterEnable,
    input wire logic cfgCycle,
    input wire logic cfgAccept,
    input wire logic cfgRetry,
    input wire logic insertEventOe,
    input wire logic insertEventOut,
    input wire logic swap_indicator_drive,
    input wire logic power_event_request_n,
    input wire logic sdaOe,
    input wire logic sclOut,
    input wire logic backend_power_good_n,
    input wire logic backendPowerStable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic sclPrev_q;
    logic sclSeen_q;
    logic [10:0] sclRun_q;
    logic [2:0] relCnt_q;
    // ----------------------------------------
    // helper counters: serial clock half period, cycles since release
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclPrev_q <= 1'b0;
            sclSeen_q <= 1'b0;
            sclRun_q <= 11'h000;
            relCnt_q <= 3'h0;
        end
        else
        begin
            sclPrev_q <= sclOut;
            sclSeen_q <= sclSeen_q | (sclOut != sclPrev_q);
            sclRun_q <= (sclOut != sclPrev_q) ? 11'h001 : sclRun_q + 11'h001;
            relCnt_q <= (relCnt_q == 3'h7) ? relCnt_q : relCnt_q + 3'h1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_lowDrive;
        !swap_indicator_drive && !insertEventOut && !power_event_request_n && !sdaOe;
    endproperty
    a_lowDrive: assert property (p_lowDrive)
        else $error("open-drain pin drives high");
    property p_cfgSplit;
        cfgCycle |-> (cfgAccept != cfgRetry);
    endproperty
    a_cfgSplit: assert property (p_cfgSplit)
        else $error("config cycle not answered once");
    property p_cfgIdle;
        !cfgCycle |-> !cfgAccept && !cfgRetry;
    endproperty
    a_cfgIdle: assert property (p_cfgIdle)
        else $error("config answer without cycle");
    property p_holdEvent;
        cfgRetry |-> !insertEventOe;
    endproperty
    a_holdEvent: assert property (p_holdEvent)
        else $error("insertion event during hold");
    property p_loadPulse;
        eepromLoadStart |-> eepromLoadEnable ##1 !eepromLoadStart;
    endproperty
    a_loadPulse: assert property (p_loadPulse)
        else $error("load start not a single pulse");
    property p_strapHold;
        relCnt_q == 3'h7 |-> $stable(arbiterEnable) && $stable(eepromLoadEnable);
    endproperty
    a_strapHold: assert property (p_strapHold)
        else $error("captured strap changed");
    property p_sclHalf;
        sclSeen_q && (sclOut != sclPrev_q) |-> sclRun_q == 11'h200;
    endproperty
    a_sclHalf: assert property (p_sclHalf)
        else $error("serial clock half period wrong");
    property p_powerBad;
        backend_power_good_n [*3] |=> !backendPowerStable;
    endproperty
    a_powerBad: assert property (p_powerBad)
        else $error("power stable while power bad");
    property p_rdIdle;
        !$past(regRdEn) |-> regRdData == 8'h00;
    endproperty
    a_rdIdle: assert property (p_rdIdle)
        else $error("read data outside read slot");
    c_retry: cover property (cfgRetry);
    c_accept: cover property (cfgAccept);
    c_loadStart: cover property (eepromLoadStart);
    c_event: cover property (insertEventOe);
endmodule // hsc_hotswap_monitor
bind hsc_hotswap_strap_control hsc_hotswap_monitor i_mon (.mclk, .rst_b, .regRdEn, .regRdData,
    .eepromLoadStart, .eepromLoadEnable, .arbiterEnable, .cfgCycle, .cfgAccept, .cfgRetry,
    .insertEventOe, .insertEventOut, .swap_indicator_drive, .power_event_request_n, .sdaOe,
    .sclOut, .backend_power_good_n, .backendPowerStable);
`default_nettype wire

/* File: hsc_host_model.sv */
// model of the host side: ejector switch, back-end power, eeprom data line, pull-ups
`timescale 1ns/1ps
`default_nettype none
module hsc_host_model (
    input wire logic latchClosed,
    input wire logic powerOk,
    input wire logic sdaHigh,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic swapIndicatorOe,
    input wire logic swap_indicator_drive,
    input wire logic insertEventOe,
    input wire logic insertEventOut,
    input wire logic powerEventOe,
    input wire logic power_event_request_n,
    output wire logic ejector_latch_sense,
    output wire logic backend_power_good_n,
    output wire logic sdaIn,
    output wire logic ledLine,
    output wire logic eventLine,
    output wire logic pmeLine
);
    // switch closes to ground when the latch opens; power-good is active low
    assign ejector_latch_sense = latchClosed;
    assign backend_power_good_n = ~powerOk;
    // data line has a pull-up; the eeprom holds it low unless left high
    assign sdaIn = sdaOe ? sdaOut : sdaHigh;
    // indicator, insertion event and power event lines all sit on pull-ups
    assign ledLine = swapIndicatorOe ? swap_indicator_drive : 1'b1;
    assign eventLine = insertEventOe ? insertEventOut : 1'b1;
    assign pmeLine = powerEventOe ? power_event_request_n : 1'b1;
endmodule // hsc_host_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the hot-swap and strap control block
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.vh"
module tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic eeprom_load_strap = 1'b0, arbiter_enable_strap = 1'b0, config_hold_strap = 1'b0;
    logic cfgCycle = 1'b0, latchClosed = 1'b1, powerOk = 1'b1, sdaHigh = 1'b0;
    wire logic [7:0] regRdData;
    wire logic ejector_latch_sense, backend_power_good_n, sdaIn, sdaOut, sdaOe, sclOut;
    wire logic swap_indicator_drive, swapIndicatorOe, insertEventOut, insertEventOe;
    wire logic power_event_request_n, powerEventOe, cfgAccept, cfgRetry, irq;
    wire logic eepromLoadEnable, eepromLoadStart, arbiterEnable, backendPowerStable;
    wire logic ledLine, eventLine, pmeLine;
    int errCount = 0, totalChecks = 0, cycles = 0, startCount = 0;
    hsc_hotswap_strap_control i_dut (.mclk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .eeprom_load_strap, .arbiter_enable_strap, .config_hold_strap,
        .ejector_latch_sense, .backend_power_good_n, .sdaIn, .sdaOut, .sdaOe, .sclOut,
        .swap_indicator_drive, .swapIndicatorOe, .insertEventOut, .insertEventOe,
        .power_event_request_n, .powerEventOe, .cfgCycle, .cfgAccept, .cfgRetry,
        .eepromLoadEnable, .eepromLoadStart, .arbiterEnable, .backendPowerStable, .irq);
    hsc_host_model i_host (.latchClosed, .powerOk, .sdaHigh, .sdaOut, .sdaOe, .swapIndicatorOe,
        .swap_indicator_drive, .insertEventOe, .insertEventOut, .powerEventOe,
        .power_event_request_n, .ejector_latch_sense, .backend_power_good_n, .sdaIn, .ledLine,
        .eventLine, .pmeLine);
    // ----------------------------------------
    // clock, load pulse counter and hang guard
    // ----------------------------------------
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (eepromLoadStart === 1'b1)
            startCount++;
        if (cycles == 30000)
        begin
            errCount++;
            results();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        tick(1);
    endtask
    task automatic rdChk(input string name, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
        chk(name, {8'h00, d}, {8'h00, e});
        tick(1);
    endtask
    task automatic doReset(input logic [3:0] s);
        rst_b <= 1'b0;
        {config_hold_strap, arbiter_enable_strap, sdaHigh, eeprom_load_strap} <= s;
        tick(12);
        startCount = 0;
        rst_b <= 1'b1;
        tick(8);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic testStraps(input logic [3:0] s);
        logic ld;
        ld = s[0] | s[1];
        doReset(s);
        {config_hold_strap, arbiter_enable_strap, sdaHigh, eeprom_load_strap} <= ~s;
        tick(6);
        rdChk("straps", `HSC_ADDR_STRAPS, {3'h0, ld, s});
        chk("arbiter", 16'(arbiterEnable), 16'(s[2]));
        chk("loadEnable", 16'(eepromLoadEnable), 16'(ld));
        chk("loadStarts", 16'(startCount), 16'(ld));
    endtask
    task automatic testHold;
        doReset(4'h8);
        rdChk("holdBit", `HSC_ADDR_MISC2, 8'h01);
        cfgCycle <= 1'b1;
        tick(1);
        chk("retryHeld", {cfgRetry, cfgAccept, eventLine}, 16'h0005);
        wr(`HSC_ADDR_MISC2, 8'h01);
        chk("retryStill", {cfgRetry, cfgAccept}, 16'h0002);
        wr(`HSC_ADDR_MISC2, 8'h00);
        chk("accepted", {cfgRetry, cfgAccept, eventLine}, 16'h0002);
        cfgCycle <= 1'b0;
        tick(1);
    endtask
    task automatic testSwap;
        doReset(4'h0);
        rdChk("swConn", `HSC_ADDR_HSCTL, 8'h22);
        chk("litAndEvent", {ledLine, eventLine}, 16'h0000);
        wr(`HSC_ADDR_HSCTL, 8'h02);
        wr(`HSC_ADDR_HSCTL, 8'h01);
        rdChk("normal", `HSC_ADDR_HSCTL, 8'h40);
        chk("ledOff", {swapIndicatorOe, ledLine, eventLine}, 16'h0003);
        wr(`HSC_ADDR_INTSTAT, 8'hFF);
        wr(`HSC_ADDR_INTMASK, 8'h01);
        latchClosed <= 1'b0;
        tick(6);
        rdChk("extract", `HSC_ADDR_HSCTL, 8'h83);
        rdChk("openEvent", `HSC_ADDR_INTSTAT, 8'h01);
        chk("irqOn", 16'(irq), 16'h0001);
        wr(`HSC_ADDR_INTMASK, 8'h00);
        chk("irqMasked", 16'(irq), 16'h0000);
        wr(`HSC_ADDR_INTMASK, 8'h01);
        wr(`HSC_ADDR_INTSTAT, 8'h01);
        chk("irqCleared", 16'(irq), 16'h0000);
    endtask
    task automatic testPower;
        wr(`HSC_ADDR_HSCTL, 8'h04);
        chk("pmeOn", 16'(pmeLine), 16'h0000);
        rdChk("pmeEvent", `HSC_ADDR_INTSTAT, 8'h10);
        wr(`HSC_ADDR_HSCTL, 8'h02);
        chk("pmeOff", 16'(pmeLine), 16'h0001);
        wr(`HSC_ADDR_INTSTAT, 8'hFF);
        powerOk <= 1'b0;
        tick(6);
        chk("unstable", {backendPowerStable, pmeLine, ledLine}, 16'h0000);
        rdChk("hwConn", `HSC_ADDR_HSCTL, 8'h15);
        rdChk("lostEvent", `HSC_ADDR_INTSTAT, 8'h08);
        rdChk("unmapped", 4'hF, 8'h00);
        powerOk <= 1'b1;
        latchClosed <= 1'b1;
        tick(6);
        rdChk("restored", `HSC_ADDR_INTSTAT, 8'h0E);
        rdChk("swAgain", `HSC_ADDR_HSCTL, 8'h26);
        chk("stableAgain", 16'(backendPowerStable), 16'h0001);
    endtask
    task automatic testScl;
        int n;
        n = 0;
        wait (sclOut === 1'b0);
        wait (sclOut === 1'b1);
        while (sclOut === 1'b1)
        begin
            tick(1);
            n++;
        end
        while (sclOut === 1'b0)
        begin
            tick(1);
            n++;
        end
        chk("sclPeriod", 16'(n), 16'h0400);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        testStraps(4'h5);
        testStraps(4'hA);
        testStraps(4'h2);
        testStraps(4'h0);
        testHold();
        testSwap();
        testPower();
        testScl();
        results();
    end
endmodule // tb_top
`default_nettype wire
